// File: rtl/mci_regs.sv
// interrupt control register slice: edge select, global enable, flags and enables
// assumes a register port on clk_sys with one-cycle strobes and read data one cycle later
// Operation
// [R1] The pin 1 edge field picks none, rising, falling or both edges for pin 1 detection.
// [R2] The pin 0 edge field uses the same code to pick which pin 0 edges raise its flag.
// [R3] The top four bits of the edge select register always read as zero.
// [R4] The global enable in bit 0 of the first control register blocks every request when clear; the code gates only irq_request, not irq_sources.
// [R5] Bit 7 of the second control register is the read-write tick 0 request flag.
// [R6] Bit 5 of the second control register is the writable group 3 request flag.
// [R7] Bit 6 of the second control register is the converter request flag.
// [R8] Bit 3 of the second control register enables tick 0 requests.
// [R9] Bit 1 of the second control register enables group 3 requests.
// [R10] Bit 0 enables group 2 on the full variant; on the small one it and the group 2 flag read 0.
// [R11] A request reaches the core only when its flag, its enable and the global enable are set; irq_sources ignores the global enable.
// [R12] All flag, enable and edge bits clear to zero at reset.
`timescale 1ns/10ps
module mci_regs #(
    parameter bit FULL_VARIANT = 1'b1
) (
    // clock and reset
    input  wire logic       clk_sys,
    input  wire logic       rst,
    // register port
    input  wire logic [7:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    output logic      [7:0] reg_rdata,
    // external pins
    input  wire logic       ext_irq_pin_zero,
    input  wire logic       ext_irq_pin_one,
    // peripheral events, one-cycle pulses
    input  wire logic       group0_event,
    input  wire logic       group1_event,
    input  wire logic       group2_event,
    input  wire logic       group3_event,
    input  wire logic       conv_event,
    input  wire logic       tick0_event,
    // towards the core
    output logic            irq_request,
    output logic      [6:0] irq_sources,
    output logic            pin1_edge_event
);
    localparam logic [7:0] CTL1_MASK = FULL_VARIANT ? mci_pkg::MASK_CTL1_FULL
                                                    : mci_pkg::MASK_CTL1_SMALL;

    // write value merged with hardware sets; a set wins over a clear
    function automatic logic [7:0] next_reg(input logic [7:0] cur,
                                            input logic       wr,
                                            input logic [7:0] wdata,
                                            input logic [7:0] set,
                                            input logic [7:0] mask);
        next_reg = ((wr ? wdata : cur) | set) & mask;
    endfunction

    logic [7:0] edge_sel;
    logic [7:0] ctl0;
    logic [7:0] ctl1;
    logic       pin0_hit;
    logic       pin1_hit;

    mci_core_if cif ();

    // address decode
    wire sel_edge = (reg_addr == mci_pkg::REG_EDGE);
    wire sel_ctl0 = (reg_addr == mci_pkg::REG_CTL0);
    wire sel_ctl1 = (reg_addr == mci_pkg::REG_CTL1);
    wire wr_edge  = reg_wr & sel_edge;
    wire wr_ctl0  = reg_wr & sel_ctl0;
    wire wr_ctl1  = reg_wr & sel_ctl1;

    wire [1:0] pin0_edge_sel = edge_sel[mci_pkg::PIN0_SEL_LSB +: 2];
    wire [1:0] pin1_edge_sel = edge_sel[mci_pkg::PIN1_SEL_LSB +: 2];

    mci_pin_edge u_pin0 (
        .clk_sys  (clk_sys),
        .rst      (rst),
        .pin      (ext_irq_pin_zero),
        .edge_sel (pin0_edge_sel),
        .hit      (pin0_hit)
    );

    mci_pin_edge u_pin1 (
        .clk_sys  (clk_sys),
        .rst      (rst),
        .pin      (ext_irq_pin_one),
        .edge_sel (pin1_edge_sel),
        .hit      (pin1_hit)
    );

    // hardware set vectors at the flag positions
    wire [7:0] set_ctl0 = ({7'h00, pin0_hit}     << mci_pkg::PIN0_FLAG_BIT)
                        | ({7'h00, group0_event} << mci_pkg::GRP0_FLAG_BIT)
                        | ({7'h00, group1_event} << mci_pkg::GRP1_FLAG_BIT);
    wire [7:0] set_ctl1 = ({7'h00, group2_event} << mci_pkg::GRP2_FLAG_BIT)
                        | ({7'h00, group3_event} << mci_pkg::GRP3_FLAG_BIT)
                        | ({7'h00, conv_event}   << mci_pkg::CONV_FLAG_BIT)
                        | ({7'h00, tick0_event}  << mci_pkg::TICK0_FLAG_BIT);

    wire [7:0] next_edge = next_reg(edge_sel, wr_edge, reg_wdata, 8'h00,
                                    mci_pkg::MASK_EDGE);                        // R1 R2 R3
    wire [7:0] next_ctl0 = next_reg(ctl0, wr_ctl0, reg_wdata, set_ctl0,
                                    mci_pkg::MASK_CTL0);                        // R2 R4
    wire [7:0] next_ctl1 = next_reg(ctl1, wr_ctl1, reg_wdata, set_ctl1,
                                    CTL1_MASK);                                 // R5 R6 R7 R10

    // read data, unmapped addresses answer zero
    wire [7:0] next_rdata = !reg_rd  ? 8'h00 :
                            sel_edge ? (edge_sel & mci_pkg::MASK_EDGE) :       // R3
                            sel_ctl0 ? ctl0 :
                            sel_ctl1 ? ctl1 : 8'h00;

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            edge_sel        <= mci_pkg::RST_EDGE;                               // R12
            ctl0            <= mci_pkg::RST_CTL0;                               // R12
            ctl1            <= mci_pkg::RST_CTL1;                               // R12
            reg_rdata       <= 8'h00;
            pin1_edge_event <= 1'b0;
        end else begin
            edge_sel        <= next_edge;
            ctl0            <= next_ctl0;
            ctl1            <= next_ctl1;
            reg_rdata       <= next_rdata;
            pin1_edge_event <= pin1_hit;                                        // R1
        end
    end

    assign cif.ctl0 = ctl0;
    assign cif.ctl1 = ctl1;

    mci_req_gate u_gate (
        .clk_sys (clk_sys),
        .rst     (rst),
        .cif     (cif.gate)
    );

    assign irq_request = cif.irq;                                               // R4 R11
    assign irq_sources = cif.sources;

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (rst);

    sequence s_rd_edge;
        reg_rd && sel_edge;
    endsequence

    sequence s_tick0_armed;
        ctl0[mci_pkg::GLB_EN_BIT] && ctl1[mci_pkg::TICK0_FLAG_BIT]
            && ctl1[mci_pkg::TICK0_EN_BIT];
    endsequence

    sequence s_grp3_armed;
        ctl0[mci_pkg::GLB_EN_BIT] && ctl1[mci_pkg::GRP3_FLAG_BIT]
            && ctl1[mci_pkg::GRP3_EN_BIT];
    endsequence

    chk_pin1_edge_out: assert property ( // R1
        pin1_hit |=> pin1_edge_event ##1 !pin1_edge_event || pin1_hit)
        else $error("pin 1 edge event not one cycle after detection");

    chk_pin1_edge_off: assert property ( // R1
        pin1_edge_sel == mci_pkg::EDGE_OFF |-> !pin1_hit)
        else $error("pin 1 edge detected while disabled");

    chk_pin0_flag_set: assert property ( // R2
        pin0_hit |=> ctl0[mci_pkg::PIN0_FLAG_BIT])
        else $error("pin 0 edge did not raise its flag");

    chk_pin0_edge_off: assert property ( // R2
        pin0_edge_sel == mci_pkg::EDGE_OFF |-> !pin0_hit)
        else $error("pin 0 edge detected while disabled");

    chk_edge_upper_zero: assert property ( // R3
        s_rd_edge |=> reg_rdata[7:4] == 4'h0)
        else $error("edge select upper bits read non-zero");

    chk_global_block: assert property ( // R4
        !ctl0[mci_pkg::GLB_EN_BIT] |=> !irq_request)
        else $error("request raised with global enable clear");

    chk_tick0_flag: assert property ( // R5
        tick0_event |=> ctl1[mci_pkg::TICK0_FLAG_BIT])
        else $error("tick 0 event lost");

    chk_tick0_write: assert property ( // R5
        wr_ctl1 && !tick0_event |=>
            ctl1[mci_pkg::TICK0_FLAG_BIT] == $past(reg_wdata[mci_pkg::TICK0_FLAG_BIT]))
        else $error("tick 0 flag did not take written value");

    chk_grp3_flag: assert property ( // R6
        group3_event |=> ctl1[mci_pkg::GRP3_FLAG_BIT])
        else $error("group 3 event lost");

    chk_conv_flag: assert property ( // R7
        conv_event |=> ctl1[mci_pkg::CONV_FLAG_BIT])
        else $error("converter event lost");

    chk_tick0_raise: assert property ( // R8
        s_tick0_armed |=> irq_request && irq_sources[6])
        else $error("enabled tick 0 request not raised");

    chk_grp3_raise: assert property ( // R9
        s_grp3_armed |=> irq_request && irq_sources[4])
        else $error("enabled group 3 request not raised");

    chk_grp2_absent: assert property ( // R10
        !FULL_VARIANT |-> !ctl1[mci_pkg::GRP2_EN_BIT] && !ctl1[mci_pkg::GRP2_FLAG_BIT])
        else $error("group 2 bits present on small variant");

    chk_req_cause: assert property ( // R11
        irq_request |-> $past(ctl0[mci_pkg::GLB_EN_BIT])
            && ($past(ctl0[6:4] & ctl0[3:1]) != 3'h0
                || $past(ctl1[7:4] & ctl1[3:0]) != 4'h0))
        else $error("request without flag, enable and global enable");

    chk_reset_clear: assert property ( // R12
        $fell(rst) |-> edge_sel == 8'h00 && ctl0 == 8'h00 && ctl1 == 8'h00
            && !irq_request)
        else $error("registers not cleared by reset");

    chk_edge_write: assert property ( // R1
        wr_edge |=> edge_sel == ($past(reg_wdata) & mci_pkg::MASK_EDGE))
        else $error("edge select did not take written value");

    chk_global_write: assert property ( // R4
        wr_ctl0 |=> ctl0[mci_pkg::GLB_EN_BIT] == $past(reg_wdata[mci_pkg::GLB_EN_BIT]))
        else $error("global enable did not take written value");

    chk_grp3_write: assert property ( // R6
        wr_ctl1 && !group3_event |=>
            ctl1[mci_pkg::GRP3_FLAG_BIT] == $past(reg_wdata[mci_pkg::GRP3_FLAG_BIT]))
        else $error("group 3 flag did not take written value");

    chk_conv_write: assert property ( // R7
        wr_ctl1 && !conv_event |=>
            ctl1[mci_pkg::CONV_FLAG_BIT] == $past(reg_wdata[mci_pkg::CONV_FLAG_BIT]))
        else $error("converter flag did not take written value");

    chk_tick0_mask: assert property ( // R8
        !ctl1[mci_pkg::TICK0_EN_BIT] |=> !irq_sources[6])
        else $error("tick 0 source shown while disabled");

    chk_grp3_mask: assert property ( // R9
        !ctl1[mci_pkg::GRP3_EN_BIT] |=> !irq_sources[4])
        else $error("group 3 source shown while disabled");

    chk_grp2_raise: assert property ( // R10
        FULL_VARIANT && ctl1[mci_pkg::GRP2_FLAG_BIT] && ctl1[mci_pkg::GRP2_EN_BIT]
            |=> irq_sources[3])
        else $error("enabled group 2 source not shown on full variant");

    chk_conv_raise: assert property ( // R11
        ctl0[mci_pkg::GLB_EN_BIT] && ctl1[mci_pkg::CONV_FLAG_BIT]
            && ctl1[mci_pkg::CONV_EN_BIT] |=> irq_request && irq_sources[5])
        else $error("enabled converter request not raised");

    chk_pin0_raise: assert property ( // R11
        ctl0[mci_pkg::GLB_EN_BIT] && ctl0[mci_pkg::PIN0_FLAG_BIT]
            && ctl0[mci_pkg::PIN0_EN_BIT] |=> irq_request && irq_sources[0])
        else $error("enabled pin 0 request not raised");
endmodule // mci_regs

// File: rtl/mci_pkg.sv
// interrupt control register slice: offsets, field positions, masks, reset values
// assumes an 8-bit register port with one-cycle strobes on clk_sys
package mci_pkg;
    // register offsets on the register port
    localparam logic [7:0] REG_EDGE = 8'h00;
    localparam logic [7:0] REG_CTL0 = 8'h01;
    localparam logic [7:0] REG_CTL1 = 8'h02;

    // reset values
    localparam logic [7:0] RST_EDGE = 8'h00;
    localparam logic [7:0] RST_CTL0 = 8'h00;
    localparam logic [7:0] RST_CTL1 = 8'h00;

    // implemented bits of each register
    localparam logic [7:0] MASK_EDGE       = 8'h0f;
    localparam logic [7:0] MASK_CTL0       = 8'h7f;
    localparam logic [7:0] MASK_CTL1_FULL  = 8'hff;
    localparam logic [7:0] MASK_CTL1_SMALL = 8'hee;

    // edge select register fields
    localparam int PIN0_SEL_LSB = 0;
    localparam int PIN1_SEL_LSB = 2;

    // edge select encoding
    localparam logic [1:0] EDGE_OFF  = 2'h0;
    localparam logic [1:0] EDGE_RISE = 2'h1;
    localparam logic [1:0] EDGE_FALL = 2'h2;
    localparam logic [1:0] EDGE_BOTH = 2'h3;
    localparam int EDGE_RISE_BIT = 0;
    localparam int EDGE_FALL_BIT = 1;

    // first control register
    localparam int GLB_EN_BIT    = 0;
    localparam int PIN0_EN_BIT   = 1;
    localparam int GRP0_EN_BIT   = 2;
    localparam int GRP1_EN_BIT   = 3;
    localparam int PIN0_FLAG_BIT = 4;
    localparam int GRP0_FLAG_BIT = 5;
    localparam int GRP1_FLAG_BIT = 6;

    // second control register
    localparam int GRP2_EN_BIT   = 0;
    localparam int GRP3_EN_BIT   = 1;
    localparam int CONV_EN_BIT   = 2;
    localparam int TICK0_EN_BIT  = 3;
    localparam int GRP2_FLAG_BIT = 4;
    localparam int GRP3_FLAG_BIT = 5;
    localparam int CONV_FLAG_BIT = 6;
    localparam int TICK0_FLAG_BIT = 7;
endpackage

// File: rtl/mci_core_if.sv
// control register contents towards the request gate and its answer
// assumes one clock domain, clk_sys
`timescale 1ns/10ps
interface mci_core_if;
    logic [7:0] ctl0;
    logic [7:0] ctl1;
    logic       irq;
    logic [6:0] sources;
    modport core (output ctl0, output ctl1, input irq, input sources);
    modport gate (input ctl0, input ctl1, output irq, output sources);
endinterface

// File: rtl/mci_pin_edge.sv
// external pin synchroniser and selectable edge detector
// assumes an asynchronous pin and a synchronous active-high reset
`timescale 1ns/10ps
module mci_pin_edge (
    // clock and reset
    input  wire logic       clk_sys,
    input  wire logic       rst,
    // pin and mode
    input  wire logic       pin,
    input  wire logic [1:0] edge_sel,
    // detected edge, one cycle
    output logic            hit
);
    logic [2:0] sync;
    logic       lvl;

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            sync <= 3'h0;
            lvl  <= 1'b0;
        end else begin
            sync <= {sync[1:0], pin};
            if (sync[1] == sync[2]) begin
                lvl <= sync[2];
            end
        end
    end

    // a change counts once the second and third stages agree
    wire settled = (sync[1] == sync[2]);
    wire rose    = settled & sync[2] & ~lvl;
    wire fell    = settled & ~sync[2] & lvl;

    assign hit = (edge_sel[mci_pkg::EDGE_RISE_BIT] & rose)              // R1 R2
               | (edge_sel[mci_pkg::EDGE_FALL_BIT] & fell);
endmodule // mci_pin_edge

// File: rtl/mci_req_gate.sv
// request gate: flag and enable pairs; the request is qualified by the global enable, the sources are not
// assumes register contents arrive from flip-flops on clk_sys
`timescale 1ns/10ps
module mci_req_gate (
    // clock and reset
    input  wire logic clk_sys,
    input  wire logic rst,
    // register contents and answer
    mci_core_if.gate  cif
);
    // flags sit three bits above their enables in the first register and four bits above in the second
    wire [2:0] pend0 = cif.ctl0[6:4] & cif.ctl0[3:1];
    wire [3:0] pend1 = cif.ctl1[7:4] & cif.ctl1[3:0];                   // R8 R9 R10
    wire       glb   = cif.ctl0[mci_pkg::GLB_EN_BIT];

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            cif.irq     <= 1'b0;
            cif.sources <= 7'h00;
        end else begin
            cif.irq     <= glb & (|{pend1, pend0});                     // R4 R11
            cif.sources <= {pend1, pend0};
        end
    end
endmodule // mci_req_gate

// File: testbench/mci_src_model.sv
// far side model: external pins and peripheral event sources
// assumes commands from the bench on clk_sys, launched by non-blocking assignment
`timescale 1ns/10ps
module mci_src_model (
    // clock and reset
    input  wire logic       clk_sys,
    input  wire logic       rst,
    // commands: {tick0,conv,grp3,grp2,grp1,grp0} and {pin1,pin0}
    input  wire logic [5:0] ev_cmd,
    input  wire logic [1:0] pin_cmd,
    // towards the block
    output logic      [5:0] ev_out,
    output logic            pin_zero,
    output logic            pin_one
);
    // pins change only on clock edges and hold for many cycles
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            ev_out   <= 6'h00;
            pin_zero <= 1'b0;
            pin_one  <= 1'b0;
        end else begin
            ev_out   <= ev_cmd;
            pin_zero <= pin_cmd[0];
            pin_one  <= pin_cmd[1];
        end
    end
endmodule // mci_src_model

// File: testbench/mci_regs_test.sv
// self-checking bench for the interrupt control register slice, both variants
// assumes the register port of mci_regs and the event model mci_src_model
`timescale 1ns/10ps
module mci_regs_test;
    logic       clk_sys = 1'b0;
    logic       rst     = 1'b1;
    logic [7:0] addr    = 8'h00;
    logic [7:0] wdata   = 8'h00;
    logic       wr      = 1'b0;
    logic       rd      = 1'b0;
    logic [5:0] ev_cmd  = 6'h00;
    logic [1:0] pin_cmd = 2'h0;
    logic [5:0] ev;
    logic       p0, p1, irq_f, irq_s, e1_f;
    logic [7:0] rdata_f, rdata_s, ef, es;
    logic [6:0] src_f, src_s;
    int         n_fail = 0, checks_done = 0, n_edge = 0, base;
    logic [7:0] ctl_tab[5] = '{8'h88, 8'h80, 8'h22, 8'h11, 8'h44};
    logic [7:0] irq_tab[5] = '{8'hc0, 8'h00, 8'h90, 8'h88, 8'ha0};

    initial forever #4 clk_sys = ~clk_sys;
    always @(posedge clk_sys) if (e1_f === 1'b1) n_edge <= n_edge + 1;

    mci_src_model mci_src_model_inst (.clk_sys(clk_sys), .rst(rst), .ev_cmd(ev_cmd),
        .pin_cmd(pin_cmd), .ev_out(ev), .pin_zero(p0), .pin_one(p1));
    mci_regs #(.FULL_VARIANT(1'b1)) mci_regs_inst (.clk_sys(clk_sys), .rst(rst),
        .reg_addr(addr), .reg_wdata(wdata), .reg_wr(wr), .reg_rd(rd), .reg_rdata(rdata_f),
        .ext_irq_pin_zero(p0), .ext_irq_pin_one(p1), .group0_event(ev[0]),
        .group1_event(ev[1]), .group2_event(ev[2]), .group3_event(ev[3]),
        .conv_event(ev[4]), .tick0_event(ev[5]), .irq_request(irq_f),
        .irq_sources(src_f), .pin1_edge_event(e1_f));
    mci_regs #(.FULL_VARIANT(1'b0)) mci_regs_inst_small (.clk_sys(clk_sys), .rst(rst),
        .reg_addr(addr), .reg_wdata(wdata), .reg_wr(wr), .reg_rd(rd), .reg_rdata(rdata_s),
        .ext_irq_pin_zero(p0), .ext_irq_pin_one(p1), .group0_event(ev[0]),
        .group1_event(ev[1]), .group2_event(ev[2]), .group3_event(ev[3]),
        .conv_event(ev[4]), .tick0_event(ev[5]), .irq_request(irq_s),
        .irq_sources(src_s), .pin1_edge_event());

    task automatic finish_test();
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task automatic check(input string nm, input logic [7:0] e, input logic [7:0] g);
        checks_done++;
        if (g !== e) begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk_sys);
        wr    <= 1'b0;
    endtask

    // read data stand only in the cycle after the strobe
    task automatic rd_reg(input logic [7:0] a, input logic [7:0] e_f, input logic [7:0] e_s);
        @(posedge clk_sys);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk_sys);
        rd   <= 1'b0;
        #1;
        check("rdata_full", e_f, rdata_f);
        check("rdata_small", e_s, rdata_s);
    endtask

    task automatic pulse(input logic [5:0] e);
        @(posedge clk_sys);
        ev_cmd <= e;
        @(posedge clk_sys);
        ev_cmd <= 6'h00;
        repeat (3) @(posedge clk_sys);
    endtask

    initial begin
        repeat (20000) @(posedge clk_sys);
        n_fail++;
        finish_test();
    end

    initial begin
        repeat (5) @(posedge clk_sys);
        rst <= 1'b0;
        #1;
        check("irq_at_reset", 8'h00, {irq_f, src_f});
        rd_reg(mci_pkg::REG_EDGE, mci_pkg::RST_EDGE, mci_pkg::RST_EDGE);
        rd_reg(mci_pkg::REG_CTL0, mci_pkg::RST_CTL0, mci_pkg::RST_CTL0);
        rd_reg(mci_pkg::REG_CTL1, mci_pkg::RST_CTL1, mci_pkg::RST_CTL1);
        wr_reg(mci_pkg::REG_EDGE, 8'hff);
        rd_reg(mci_pkg::REG_EDGE, 8'h0f, 8'h0f);
        rd_reg(8'h05, 8'h00, 8'h00);
        wr_reg(mci_pkg::REG_CTL1, 8'hff);
        rd_reg(mci_pkg::REG_CTL1, 8'hff, 8'hee);
        wr_reg(mci_pkg::REG_CTL1, 8'h00);
        // each event source sets only its own flag
        for (int i = 0; i < 6; i++) begin
            pulse(6'(1 << i));
            ef = (i < 2) ? 8'(8'h20 << i) : 8'h00;
            rd_reg(mci_pkg::REG_CTL0, ef, ef);
            ef = (i < 2) ? 8'h00 : 8'(8'h10 << (i - 2));
            rd_reg(mci_pkg::REG_CTL1, ef, ef & 8'hee);
            wr_reg(mci_pkg::REG_CTL0, 8'h00);
            wr_reg(mci_pkg::REG_CTL1, 8'h00);
        end
        // request gating with the global enable off, then on
        wr_reg(mci_pkg::REG_CTL1, 8'h88);
        repeat (2) @(posedge clk_sys);
        #1;
        check("irq_global_off", 8'h40, {irq_f, src_f});
        wr_reg(mci_pkg::REG_CTL0, 8'h01);
        for (int i = 0; i < 5; i++) begin
            wr_reg(mci_pkg::REG_CTL1, ctl_tab[i]);
            repeat (2) @(posedge clk_sys);
            #1;
            check("irq_full", irq_tab[i], {irq_f, src_f});
            es = (i == 3) ? 8'h00 : irq_tab[i];
            check("irq_small", es, {irq_s, src_s});
        end
        wr_reg(mci_pkg::REG_CTL1, 8'h00);
        // every edge code on both pins, rising then falling
        for (int s = 0; s < 4; s++) begin
            for (int k = 0; k < 2; k++) begin
                wr_reg(mci_pkg::REG_CTL0, 8'h00);
                wr_reg(mci_pkg::REG_EDGE, 8'(s * 5));
                base = n_edge;
                @(posedge clk_sys);
                pin_cmd <= (k == 0) ? 2'h3 : 2'h0;
                repeat (10) @(posedge clk_sys);
                ef = ((s >> k) & 1) ? 8'h10 : 8'h00;
                rd_reg(mci_pkg::REG_CTL0, ef, ef);
                check("pin1_edges", 8'((s >> k) & 1), 8'(n_edge - base));
            end
        end
        // first control register: top bit absent, every pair raises its source
        wr_reg(mci_pkg::REG_CTL0, 8'hff);
        rd_reg(mci_pkg::REG_CTL0, 8'h7f, 8'h7f);
        check("irq_ctl0_full", 8'h87, {irq_f, src_f});
        check("irq_ctl0_small", 8'h87, {irq_s, src_s});
        // reset in mid-run clears everything again
        @(posedge clk_sys);
        rst <= 1'b1;
        repeat (5) @(posedge clk_sys);
        rst <= 1'b0;
        #1;
        check("irq_after_reset", 8'h00, {irq_f, src_f});
        rd_reg(mci_pkg::REG_CTL0, mci_pkg::RST_CTL0, mci_pkg::RST_CTL0);
        rd_reg(mci_pkg::REG_EDGE, mci_pkg::RST_EDGE, mci_pkg::RST_EDGE);
        finish_test();
    end
endmodule // mci_regs_test
